// [src/psf_pkg.sv]
/*
 * Constants for the loop state override register bank: register offsets,
 * reset values, field layout and the encoding of the loop controller states.
 * Assumes an 8-bit register port with 8-bit addresses behind the serial port.
 */
package psf_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] PSF_ADDR_PLL_STATE_OVERRIDE = 8'h32;
   localparam logic [7:0] PSF_ADDR_REF_SEL_FORCE = 8'h33;

   localparam logic [7:0] PSF_RST_PLL_STATE_OVERRIDE = 8'h00;
   localparam logic [7:0] PSF_RST_REF_SEL_FORCE = 8'h0f;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int PSF_OVR_CODE_LSB = 0;
   localparam int PSF_OVR_CODE_W = 3;
   localparam logic [7:0] PSF_OVR_RD_MASK = 8'h07;

   // ************************************************************
   // Override codes
   // ************************************************************
   localparam logic [2:0] PSF_CODE_AUTO = 3'h0;
   localparam logic [2:0] PSF_CODE_UNUSED = 3'h3;

   // Loop controller states, coded as the override field codes them
   typedef enum logic [2:0] {
      PSF_ST_FREE_RUN = 3'b001,
      PSF_ST_HOLDOVER = 3'b010,
      PSF_ST_LOCKED = 3'b100,
      PSF_ST_PRE_LOCKED = 3'b101,
      PSF_ST_PRE_LOCKED2 = 3'b110,
      PSF_ST_PHASE_LOST = 3'b111
   } psf_state_t;

   localparam psf_state_t PSF_ST_RESET = PSF_ST_FREE_RUN;

endpackage : psf_pkg

// [src/psf_loop_fsm.sv]
/*
 * Loop controller state machine of the main digital loop.
 * Assumes monitor inputs come from logic on clk_i and need no synchronising,
 * and that the override code is already decoded by the register bank.
 */
`timescale 1ns/1ps

module psf_loop_fsm (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic force_i,
   input wire logic force_valid_i,
   input wire psf_pkg::psf_state_t force_state_i,
   input wire logic ref_valid_i,
   input wire logic phase_locked_i,
   input wire logic phase_lost_i,
   output psf_pkg::psf_state_t state_o
);
   import psf_pkg::*;

   psf_state_t state_ff;
   psf_state_t nxt_state;
   psf_state_t auto_state;

   // ************************************************************
   // Autonomous transitions from the input monitors
   // ************************************************************
   always_comb begin
      auto_state = state_ff;
      unique case (state_ff)
         PSF_ST_FREE_RUN: begin
            if (ref_valid_i) begin
               auto_state = PSF_ST_PRE_LOCKED;
            end
         end
         PSF_ST_HOLDOVER: begin
            if (ref_valid_i) begin
               auto_state = PSF_ST_PRE_LOCKED2;
            end
         end
         PSF_ST_PRE_LOCKED, PSF_ST_PRE_LOCKED2: begin
            if (!ref_valid_i) begin
               auto_state = PSF_ST_FREE_RUN;
            end else if (phase_locked_i) begin
               auto_state = PSF_ST_LOCKED;
            end
         end
         PSF_ST_LOCKED: begin
            if (!ref_valid_i) begin
               auto_state = PSF_ST_HOLDOVER;
            end else if (phase_lost_i) begin
               auto_state = PSF_ST_PHASE_LOST;
            end
         end
         PSF_ST_PHASE_LOST: begin
            if (!ref_valid_i) begin
               auto_state = PSF_ST_HOLDOVER;
            end else if (phase_locked_i) begin
               auto_state = PSF_ST_LOCKED;
            end
         end
         default: begin
            // Illegal codes recover to the safe state
            auto_state = PSF_ST_FREE_RUN;
         end
      endcase
   end

   // ************************************************************
   // Force versus automatic control
   // ************************************************************
   always_comb begin
      if (!force_i) begin
         nxt_state = auto_state;
      end else if (force_valid_i) begin
         nxt_state = force_state_i;
      end else begin
         // Unused code: monitors blocked, state simply held
         nxt_state = state_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_ff <= PSF_ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign state_o = state_ff;

endmodule : psf_loop_fsm

// [src/psf_state_force_regs.sv]
/*
 * Override register bank for the main digital loop controller: the state
 * override register, the reference selection force register, and the loop
 * controller state machine that the override steers.
 * Assumes a single-cycle register port on clk_i driven by the serial port
 * logic, and monitor inputs generated on clk_i.
 */
`timescale 1ns/1ps


module psf_state_force_regs (
   input wire logic clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Input monitor results
   input wire logic ref_valid_i,
   input wire logic phase_locked_i,
   input wire logic phase_lost_i,
   // Loop control outputs
   output psf_pkg::psf_state_t loop_state_o,
   output logic loop_forced_o,
   output logic [7:0] ref_sel_force_o
);
   import psf_pkg::*;

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [PSF_OVR_CODE_W-1:0] loop_state_override_code_ff;
   logic [PSF_OVR_CODE_W-1:0] nxt_loop_state_override_code;
   logic [7:0] ref_sel_force_ff;
   logic [7:0] nxt_ref_sel_force;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   logic hit_override;
   logic hit_ref_force;

   assign hit_override = (reg_addr_i == PSF_ADDR_PLL_STATE_OVERRIDE);
   assign hit_ref_force = (reg_addr_i == PSF_ADDR_REF_SEL_FORCE);

   // ************************************************************
   // Register writes
   // ************************************************************
   always_comb begin
      nxt_loop_state_override_code = loop_state_override_code_ff;
      nxt_ref_sel_force = ref_sel_force_ff;
      if (reg_wr_i && hit_override) begin
         // Upper bits are not implemented and are dropped
         nxt_loop_state_override_code =
            reg_wdata_i[PSF_OVR_CODE_LSB +: PSF_OVR_CODE_W];
      end
      if (reg_wr_i && hit_ref_force) begin
         nxt_ref_sel_force = reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         loop_state_override_code_ff <=
            PSF_RST_PLL_STATE_OVERRIDE[PSF_OVR_CODE_LSB +: PSF_OVR_CODE_W];
         ref_sel_force_ff <= PSF_RST_REF_SEL_FORCE;
      end else begin
         loop_state_override_code_ff <= nxt_loop_state_override_code;
         ref_sel_force_ff <= nxt_ref_sel_force;
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   // Read data is registered: valid one cycle after the read strobe and
   // held until the next read, so a slow serial shifter can pick it up.
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd_i) begin
         if (hit_override) begin
            nxt_rdata = 8'h00;
            nxt_rdata[PSF_OVR_CODE_LSB +: PSF_OVR_CODE_W] =
               loop_state_override_code_ff;
            nxt_rdata = nxt_rdata & PSF_OVR_RD_MASK;
         end else if (hit_ref_force) begin
            nxt_rdata = ref_sel_force_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // ************************************************************
   // Override decode
   // ************************************************************
   logic force_active;
   logic force_valid;
   psf_state_t force_state;

   always_comb begin
      force_active = (loop_state_override_code_ff != PSF_CODE_AUTO);
      force_valid = 1'b0;
      force_state = PSF_ST_FREE_RUN;
      unique case (loop_state_override_code_ff)
         PSF_CODE_AUTO: begin
            force_valid = 1'b0;
         end
         PSF_CODE_UNUSED: begin
            // Selects no state; machine is frozen where it stands
            force_valid = 1'b0;
         end
         3'h1: begin
            force_valid = 1'b1;
            force_state = PSF_ST_FREE_RUN;
         end
         3'h2: begin
            force_valid = 1'b1;
            force_state = PSF_ST_HOLDOVER;
         end
         3'h4: begin
            force_valid = 1'b1;
            force_state = PSF_ST_LOCKED;
         end
         3'h5: begin
            force_valid = 1'b1;
            force_state = PSF_ST_PRE_LOCKED;
         end
         3'h6: begin
            force_valid = 1'b1;
            force_state = PSF_ST_PRE_LOCKED2;
         end
         3'h7: begin
            force_valid = 1'b1;
            force_state = PSF_ST_PHASE_LOST;
         end
      endcase
   end

   // ************************************************************
   // Loop controller
   // ************************************************************
   // Forcing bypasses all monitor supervision; software must take over the
   // job of watching the reference while a code is held.
   psf_loop_fsm u_loop_fsm (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .force_i(force_active),
      .force_valid_i(force_valid),
      .force_state_i(force_state),
      .ref_valid_i(ref_valid_i),
      .phase_locked_i(phase_locked_i),
      .phase_lost_i(phase_lost_i),
      .state_o(loop_state_o)
   );

   assign loop_forced_o = force_active;
   assign ref_sel_force_o = ref_sel_force_ff;

endmodule : psf_state_force_regs

// [tb/psf_regs_assertions.sv]
/* Checker for the loop state override bank, watching only its top ports.
   Assumes one clock clk_i and the synchronous active-high reset srst_i. */
`timescale 1ns/1ps
module psf_regs_chk (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire psf_pkg::psf_state_t loop_state_o,
   input wire logic loop_forced_o,
   input wire logic [7:0] ref_sel_force_o
);
   import psf_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // **********************************************
   // Override and register port
   // **********************************************
   wire ovr_wr = reg_wr_i && reg_addr_i == PSF_ADDR_PLL_STATE_OVERRIDE;
   wire ovr_ok = reg_wdata_i[2:0] != PSF_CODE_AUTO && reg_wdata_i[2:0] != PSF_CODE_UNUSED;
   force_jump_a: assert property (ovr_wr && ovr_ok ##1 !ovr_wr |-> loop_forced_o
      ##1 {5'h00, loop_state_o} == ($past(reg_wdata_i, 2) & PSF_OVR_RD_MASK))
      else $error("forced state not reached");
   auto_release_a: assert property (ovr_wr && reg_wdata_i[2:0] == PSF_CODE_AUTO
      |=> !loop_forced_o) else $error("zero code left loop forced");
   forced_hold_a: assert property ((loop_forced_o && !reg_wr_i) [*2]
      |=> $stable(loop_state_o)) else $error("forced state moved");
   reset_values_a: assert property ($fell(srst_i) |-> !loop_forced_o
      && loop_state_o == PSF_ST_RESET && ref_sel_force_o == PSF_RST_REF_SEL_FORCE)
      else $error("wrong values after reset");
   ref_write_a: assert property (reg_wr_i && reg_addr_i == PSF_ADDR_REF_SEL_FORCE
      |=> ref_sel_force_o == $past(reg_wdata_i)) else $error("reference write lost");
   read_ref_a: assert property (reg_rd_i && reg_addr_i == PSF_ADDR_REF_SEL_FORCE
      |=> reg_rdata_o == $past(ref_sel_force_o)) else $error("reference read wrong");
   read_unmapped_a: assert property (reg_rd_i && reg_addr_i != PSF_ADDR_REF_SEL_FORCE
      && reg_addr_i != PSF_ADDR_PLL_STATE_OVERRIDE |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   read_ovr_a: assert property (reg_rd_i && !reg_wr_i && reg_addr_i ==
      PSF_ADDR_PLL_STATE_OVERRIDE |=> reg_rdata_o[7:3] == 5'h00
      && (reg_rdata_o != 8'h00) == loop_forced_o) else $error("override read wrong");
endmodule : psf_regs_chk

bind psf_state_force_regs psf_regs_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .loop_state_o(loop_state_o),
   .loop_forced_o(loop_forced_o), .ref_sel_force_o(ref_sel_force_o));

// [tb/testbench.sv]
/* Self-checking bench for the loop state override bank.
   Assumes the checker is bound from its own file; inputs change 2 ns after edges. */
`timescale 1ns/1ps
module testbench;
   import psf_pkg::*;
   logic clk_i = 0, srst_i = 1, wr = 0, rd = 0, rv = 0, pk = 0, pl = 0, forced;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, refo, q;
   psf_state_t st;
   int fail_count = 0, n_checks = 0;
   localparam logic [7:0] a_ovr = PSF_ADDR_PLL_STATE_OVERRIDE;
   localparam logic [7:0] a_ref = PSF_ADDR_REF_SEL_FORCE;
   logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
   psf_state_force_regs u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .ref_valid_i(rv), .phase_locked_i(pk), .phase_lost_i(pl), .loop_state_o(st),
      .loop_forced_o(forced), .ref_sel_force_o(refo));
   initial forever #12.5 clk_i = ~clk_i;
   // **********************************************
   // Bus and compare helpers
   // **********************************************
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #2;
      end
   endtask : cyc
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      cyc(1);
      wr = 0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      addr = a;
      rd = 1;
      cyc(1);
      rd = 0;
      q = rdata;
   endtask : rd_reg
   task automatic step(input logic v, input logic k, input logic l, input psf_state_t e);
      rv = v;
      pk = k;
      pl = l;
      cyc(1);
      chk("auto_state", {5'h0, e}, {5'h0, st});
   endtask : step
   // **********************************************
   // Scenarios
   // **********************************************
   task automatic t_reset;
      chk("state", {5'h0, PSF_ST_FREE_RUN}, {5'h0, st});
      chk("forced", 8'h00, {7'h0, forced});
      chk("ref_out", 8'h0f, refo);
      rd_reg(a_ovr);
      chk("ovr_read", 8'h00, q);
      cyc(1);
      rd_reg(a_ref);
      chk("ref_read", 8'h0f, q);
   endtask : t_reset
   // Codes follow each other directly; upper bits are junk and must be dropped
   task automatic t_codes;
      foreach (codes[i]) begin
         rv = 1;
         pk = 1;
         pl = 1;
         wr_reg(a_ovr, {5'h1f, codes[i]});
         chk("forced", 8'h01, {7'h0, forced});
         cyc(1);
         chk("state", {5'h0, codes[i]}, {5'h0, st});
         rv = 0;
         pk = ~pk;
         cyc(3);
         chk("held", {5'h0, codes[i]}, {5'h0, st});
         rd_reg(a_ovr);
         chk("ovr_read", {5'h0, codes[i]}, q);
      end
   endtask : t_codes
   task automatic t_auto;
      wr_reg(a_ovr, {5'h0, PSF_CODE_UNUSED});
      rv = 1;
      pk = 1;
      cyc(2);
      chk("unused", {5'h0, PSF_ST_PHASE_LOST}, {5'h0, st});
      chk("unused_forced", 8'h01, {7'h0, forced});
      rv = 0;
      wr_reg(a_ovr, 8'h00); // Bench has supervised the loop, hands it back
      chk("released", 8'h00, {7'h0, forced});
      step(1'b0, 1'b0, 1'b0, PSF_ST_HOLDOVER);
      step(1'b1, 1'b0, 1'b0, PSF_ST_PRE_LOCKED2);
      step(1'b1, 1'b1, 1'b0, PSF_ST_LOCKED);
      step(1'b1, 1'b0, 1'b1, PSF_ST_PHASE_LOST);
   endtask : t_auto
   // A read in the same cycle as a write must still see the old contents
   task automatic t_regs;
      wr_reg(a_ref, 8'ha5);
      chk("ref_out", 8'ha5, refo);
      cyc(1);
      wdata = 8'h5a;
      wr = 1;
      rd_reg(a_ref);
      wr = 0;
      chk("ref_old", 8'ha5, q);
      chk("ref_new", 8'h5a, refo);
      cyc(1);
      rd_reg(8'h40);
      chk("unmapped", 8'h00, q);
   endtask : t_regs
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   initial begin
      cyc(2);
      srst_i = 0;
      t_reset;
      t_codes;
      t_auto;
      t_regs;
      wr_reg(a_ovr, 8'h04);
      srst_i = 1;
      cyc(2);
      srst_i = 0;
      t_reset;
      give_verdict;
   end
   initial begin
      #100000;
      fail_count++;
      give_verdict;
   end
endmodule : testbench
